// ### common/ulmac_pkg.sv
// shared types and constants for the u-line maintenance and activation control block
package ulmac_pkg;
   // activation status nibble bit positions
   localparam int unsigned STAT_LINKUP_BIT = 3;
   localparam int unsigned STAT_SFS_BIT = 1;
   localparam int unsigned STAT_AIP_BIT = 0;
   // reset and activation control nibble bit positions
   localparam int unsigned SW_RESET_BIT = 3;
   localparam int unsigned ACT_REQ_BIT = 3;
   // m4 bit positions checked three times in trinal mode (act, dea, uoa)
   localparam logic [7:0] M4_TRINAL_MASK = 8'hE0;
   // reset values of the maintenance bytes
   localparam logic [7:0] M4_TX_RESET = 8'h77;
   localparam logic [7:0] M4_RX_RESET = 8'h7F;
   localparam logic [7:0] M56_RESET = 8'hFF;
   localparam logic [8:0] EOC_RESET = 9'h1FF;
   // gci frames per superframe
   localparam logic [6:0] FRAMES_PER_SF = 7'h60;
   // eoc message field for the loopback command handled in automatic mode
   localparam logic [7:0] EOC_CMD_LOOPBACK = 8'h50;
   localparam logic [7:0] EOC_CMD_RETURN_NORMAL = 8'hFF;

   typedef enum logic [2:0] {
      ULMAC_RESET, ULMAC_PENDING, ULMAC_SYNC, ULMAC_TRANSPARENT, ULMAC_NORMAL, ULMAC_TEARDOWN
   } ulmac_act_state_t;

   typedef struct packed {
      logic [3:0] nibble;
      logic write;
   } ulmac_nib_wr_t;

   typedef struct packed {
      logic linkup;
      logic superframe_sync_flag;
      logic frame_tick;
      logic crc_err_far;
      logic crc_err_near;
      logic m_valid;
      logic [7:0] m4_rx;
      logic [7:0] m56_rx;
      logic eoc_valid;
      logic [8:0] eoc_rx;
   } ulmac_line_in_t;
endpackage

// ### logic/ulmac_ctl.sv
// maintenance channel access and activation control for the u-line transceiver
`timescale 1ns/1ps
module ulmac_ctl (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire ulmac_pkg::ulmac_nib_wr_t reset_ctl_wr,
   input wire ulmac_pkg::ulmac_nib_wr_t act_ctl_wr,
   input wire logic m4_tx_wr,
   input wire logic m56_tx_wr,
   input wire logic eoc_wr,
   input wire logic [8:0] wr_data,
   input wire logic fe_clear,
   input wire logic ne_clear,
   input wire logic auto_eoc_mode,
   input wire logic m4_trinal_mode,
   input wire logic gci_master,
   input wire logic line_signal,
   input wire ulmac_pkg::ulmac_line_in_t line_in,
   output logic [3:0] activation_status_nibble,
   output logic [7:0] m4_transmit_byte,
   output logic [7:0] m4_receive_byte,
   output logic [7:0] m56_transmit_byte,
   output logic [7:0] m56_receive_byte,
   output logic [8:0] embedded_ops_register,
   output logic [8:0] eoc_tx,
   output logic [7:0] far_end_error_counter,
   output logic [7:0] near_end_error_counter,
   output logic warm_start_enable,
   output logic soft_reset,
   output logic loopback_active,
   output logic frame_sync_pulse
);
   typedef struct packed {
      ulmac_pkg::ulmac_act_state_t state;
      logic soft_reset;
      logic act_req;
      logic warm_start;
      logic [3:0] status;
      logic [7:0] m4_tx;
      logic [7:0] m56_tx;
      logic [8:0] eoc_tx;
      logic [8:0] eoc_rx;
      logic [7:0] fe_cnt;
      logic [7:0] ne_cnt;
      logic loopback;
      logic [6:0] frame_cnt;
      logic fsync;
      logic [7:0] m4_rx;
      logic [7:0] m56_rx;
      logic [2:0] sig_sync;
      logic sig_acc;
   } ulmac_ctl_st_t;

   logic [1:0] rst_pipe;
   logic rst_sync_b;
   ulmac_ctl_st_t st;
   ulmac_ctl_st_t next_st;
   logic [7:0] m4_qual;
   logic [8:0] eoc_qual;
   logic sig_ok;

   // two-stage reset release
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe[1];

   ulmac_trinal #(.W(8)) u_m4_check (
      .ref_clk(ref_clk),
      .rst_sync_b(rst_sync_b),
      .sample(line_in.m_valid),
      .raw(line_in.m4_rx),
      .mask3(m4_trinal_mode ? ulmac_pkg::M4_TRINAL_MASK : 8'h00),
      .reset_val(ulmac_pkg::M4_RX_RESET),
      .held(m4_qual)
   );

   ulmac_trinal #(.W(9)) u_eoc_check (
      .ref_clk(ref_clk),
      .rst_sync_b(rst_sync_b),
      .sample(line_in.eoc_valid),
      .raw(line_in.eoc_rx),
      .mask3(9'h1FF),
      .reset_val(ulmac_pkg::EOC_RESET),
      .held(eoc_qual)
   );

   function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic hit);
      sat_inc = (hit && v != 8'hFF) ? v + 8'h01 : v;
   endfunction

   // line signal pin: accepted once stages two and three agree
   assign sig_ok = st.sig_acc;

   always_comb begin
      next_st = st;
      next_st.sig_sync = {st.sig_sync[1:0], line_signal};
      // one stray sample between stages two and three is never taken
      if (st.sig_sync[1] == st.sig_sync[2]) begin
         next_st.sig_acc = st.sig_sync[2];
      end
      next_st.fsync = 1'b0;
      if (reset_ctl_wr.write) begin
         next_st.soft_reset = reset_ctl_wr.nibble[ulmac_pkg::SW_RESET_BIT];
      end
      if (act_ctl_wr.write) begin
         next_st.act_req = act_ctl_wr.nibble[ulmac_pkg::ACT_REQ_BIT];
      end
      if (m4_tx_wr) begin
         next_st.m4_tx = wr_data[7:0];
      end
      if (m56_tx_wr) begin
         next_st.m56_tx = wr_data[7:0];
      end
      next_st.m4_rx = m4_qual;
      if (line_in.m_valid) begin
         next_st.m56_rx = line_in.m56_rx;
      end
      if (eoc_wr) begin
         next_st.eoc_tx = wr_data;
      end
      next_st.eoc_rx = eoc_qual;
      if (auto_eoc_mode && eoc_qual != st.eoc_rx) begin
         next_st.eoc_tx = eoc_qual;
         if (eoc_qual[7:0] == ulmac_pkg::EOC_CMD_LOOPBACK) begin
            next_st.loopback = 1'b1;
         end else if (eoc_qual[7:0] == ulmac_pkg::EOC_CMD_RETURN_NORMAL) begin
            next_st.loopback = 1'b0;
         end
      end
      if (fe_clear) begin
         next_st.fe_cnt = 8'h00;
      end else begin
         next_st.fe_cnt = sat_inc(st.fe_cnt, line_in.crc_err_far);
      end
      if (ne_clear) begin
         next_st.ne_cnt = 8'h00;
      end else begin
         next_st.ne_cnt = sat_inc(st.ne_cnt, line_in.crc_err_near);
      end
      if (line_in.frame_tick) begin
         if (st.frame_cnt == ulmac_pkg::FRAMES_PER_SF - 7'h01) begin
            next_st.frame_cnt = 7'h00;
            next_st.fsync = gci_master;
         end else begin
            next_st.frame_cnt = st.frame_cnt + 7'h01;
         end
      end
      case (st.state)
         ulmac_pkg::ULMAC_RESET: begin
            next_st.status = 4'h0;
            if (st.act_req || sig_ok) begin
               next_st.state = ulmac_pkg::ULMAC_PENDING;
            end
         end
         ulmac_pkg::ULMAC_PENDING: begin
            next_st.status[ulmac_pkg::STAT_AIP_BIT] = 1'b1;
            if (line_in.linkup) begin
               next_st.state = ulmac_pkg::ULMAC_SYNC;
            end else if (!sig_ok && !st.act_req) begin
               next_st.state = ulmac_pkg::ULMAC_TEARDOWN;
            end
         end
         ulmac_pkg::ULMAC_SYNC: begin
            next_st.status[ulmac_pkg::STAT_LINKUP_BIT] = 1'b1;
            next_st.status[ulmac_pkg::STAT_SFS_BIT] = line_in.superframe_sync_flag;
            if (!sig_ok) begin
               next_st.state = ulmac_pkg::ULMAC_TEARDOWN;
            end else if (line_in.superframe_sync_flag) begin
               next_st.state = ulmac_pkg::ULMAC_TRANSPARENT;
            end
         end
         ulmac_pkg::ULMAC_TRANSPARENT, ulmac_pkg::ULMAC_NORMAL: begin
            next_st.status[ulmac_pkg::STAT_SFS_BIT] = line_in.superframe_sync_flag;
            if (!sig_ok) begin
               next_st.state = ulmac_pkg::ULMAC_TEARDOWN;
            end else if (!line_in.superframe_sync_flag) begin
               next_st.state = ulmac_pkg::ULMAC_SYNC;
            end else if (m4_qual[7]) begin
               next_st.state = ulmac_pkg::ULMAC_NORMAL;
            end
         end
         ulmac_pkg::ULMAC_TEARDOWN: begin
            next_st.status = 4'h0;
            next_st.state = ulmac_pkg::ULMAC_RESET;
         end
         default: begin
            next_st.state = ulmac_pkg::ULMAC_RESET;
         end
      endcase
      if (next_st.state != st.state) begin
         next_st.warm_start = (next_st.state == ulmac_pkg::ULMAC_TEARDOWN) &&
            (st.state inside {ulmac_pkg::ULMAC_PENDING, ulmac_pkg::ULMAC_SYNC,
                              ulmac_pkg::ULMAC_TRANSPARENT, ulmac_pkg::ULMAC_NORMAL});
      end
      // software reset forces the machine back while leaving host bytes and counters
      if (st.soft_reset) begin
         next_st.state = ulmac_pkg::ULMAC_RESET;
         next_st.status = 4'h0;
         next_st.warm_start = 1'b0;
         next_st.loopback = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st <= '0;
         st.state <= ulmac_pkg::ULMAC_RESET;
         st.m4_tx <= ulmac_pkg::M4_TX_RESET;
         st.m56_tx <= ulmac_pkg::M56_RESET;
         st.eoc_tx <= ulmac_pkg::EOC_RESET;
         st.eoc_rx <= ulmac_pkg::EOC_RESET;
         st.m4_rx <= ulmac_pkg::M4_RX_RESET;
         st.m56_rx <= ulmac_pkg::M56_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign activation_status_nibble = st.status;
   assign m4_transmit_byte = st.m4_tx;
   assign m4_receive_byte = st.m4_rx;
   assign m56_transmit_byte = st.m56_tx;
   assign m56_receive_byte = st.m56_rx;
   assign embedded_ops_register = st.eoc_rx;
   assign eoc_tx = st.eoc_tx;
   assign far_end_error_counter = st.fe_cnt;
   assign near_end_error_counter = st.ne_cnt;
   assign warm_start_enable = st.warm_start;
   assign soft_reset = st.soft_reset;
   assign loopback_active = st.loopback;
   assign frame_sync_pulse = st.fsync;
endmodule

// ### logic/ulmac_trinal.sv
// qualifier for received m4 and eoc words: three in a row on mask3 bits, two in a row on the others
`timescale 1ns/1ps
module ulmac_trinal #(
   parameter int unsigned W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_sync_b,
   input wire logic sample,
   input wire logic [W-1:0] raw,
   input wire logic [W-1:0] mask3,
   input wire logic [W-1:0] reset_val,
   output logic [W-1:0] held
);
   typedef struct packed {
      logic primed;
      logic [W-1:0] last;
      logic [W-1:0] prev;
      logic [W-1:0] held;
   } ulmac_tri_st_t;

   ulmac_tri_st_t st;
   ulmac_tri_st_t next_st;
   logic [W-1:0] same3;
   logic [W-1:0] same2;

   always_comb begin
      next_st = st;
      same3 = ~(raw ^ st.last) & ~(st.last ^ st.prev);
      same2 = ~(raw ^ st.last);
      next_st.primed = 1'b1;
      // history starts at the reset value so cleared flops never pass as samples
      if (!st.primed) begin
         next_st.last = reset_val;
         next_st.prev = reset_val;
         next_st.held = reset_val;
      end else if (sample) begin
         next_st.prev = st.last;
         next_st.last = raw;
         for (int i = 0; i < W; i++) begin
            if (mask3[i] ? same3[i] : same2[i]) begin
               next_st.held[i] = raw[i];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // reset value loaded by logic so the async reset branch stays constant
   assign held = st.primed ? st.held : reset_val;
endmodule

// ### sim/u_line_maintenance_activation_ctl_test.sv
// self-checking bench for the maintenance and activation control block
`timescale 1ns/1ps
module u_line_maintenance_activation_ctl_test;
   typedef struct {int k; logic [8:0] e;} ulmac_note_t;
   localparam logic [8:0] rst_v [7] = '{9'h077, 9'h0FF, 9'h1FF, 9'h07F, 9'h0FF, 9'h1FF, 9'h000};
   logic ref_clk, rst_b, fe_clear, ne_clear, auto_eoc_mode, m4_trinal_mode, gci_master;
   logic line_signal, m4_tx_wr, m56_tx_wr, eoc_wr, warm_start_enable, soft_reset;
   logic loopback_active, frame_sync_pulse;
   logic [3:0] activation_status_nibble;
   logic [7:0] m4_transmit_byte, m4_receive_byte, m56_transmit_byte, m56_receive_byte;
   logic [7:0] far_end_error_counter, near_end_error_counter;
   logic [8:0] wr_data, embedded_ops_register, eoc_tx, d, ov [13];
   logic [8:0] fs_cnt = 9'h000;
   logic [31:0] seed = 32'h0000_8132;
   ulmac_pkg::ulmac_nib_wr_t reset_ctl_wr, act_ctl_wr;
   ulmac_pkg::ulmac_line_in_t line_in;
   ulmac_note_t notes[$];
   int err_total = 0, n_compared = 0, cyc = 0, i;
   ulmac_ctl ulmac_ctl_i (.ref_clk, .rst_b, .reset_ctl_wr, .act_ctl_wr, .m4_tx_wr, .m56_tx_wr,
      .eoc_wr, .wr_data, .fe_clear, .ne_clear, .auto_eoc_mode, .m4_trinal_mode, .gci_master,
      .line_signal, .line_in, .activation_status_nibble, .m4_transmit_byte, .m4_receive_byte,
      .m56_transmit_byte, .m56_receive_byte, .embedded_ops_register, .eoc_tx,
      .far_end_error_counter, .near_end_error_counter, .warm_start_enable, .soft_reset,
      .loopback_active, .frame_sync_pulse);
   ulmac_host ulmac_host_i (.ref_clk, .reset_ctl_wr, .act_ctl_wr, .m4_tx_wr, .m56_tx_wr,
      .eoc_wr, .wr_data);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always_comb ov = '{{1'b0, m4_transmit_byte}, {1'b0, m56_transmit_byte}, eoc_tx,
      {1'b0, m4_receive_byte}, {1'b0, m56_receive_byte}, embedded_ops_register,
      {5'h00, activation_status_nibble & 4'hE}, {8'h00, loopback_active},
      {8'h00, warm_start_enable}, {8'h00, soft_reset}, {1'b0, far_end_error_counter},
      {1'b0, near_end_error_counter}, fs_cnt};
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic exp(input int k, input logic [8:0] e);
      notes.push_back('{k, e});
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] want);
      n_compared++;
      if (seen !== want) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // w: frame_tick, crc_far, crc_near, eoc_valid, m_valid
   task automatic pls(input logic [4:0] w, input logic [8:0] v);
      @(posedge ref_clk);
      {line_in.frame_tick, line_in.crc_err_far, line_in.crc_err_near, line_in.eoc_valid,
         line_in.m_valid} <= w;
      {line_in.m4_rx, line_in.m56_rx, line_in.eoc_rx} <= {v[7:0], ~v[7:0], v};
      @(posedge ref_clk);
      {line_in.frame_tick, line_in.crc_err_far, line_in.crc_err_near, line_in.eoc_valid,
         line_in.m_valid} <= 5'h00;
      repeat (3) @(posedge ref_clk);
   endtask
   always @(negedge ref_clk) begin
      while (notes.size() > 0) begin
         check(ov[notes[0].k], notes[0].e);
         void'(notes.pop_front());
      end
   end
   // ceiling well above the roughly 1600 cycles the sequence needs
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      fs_cnt <= fs_cnt + 9'(frame_sync_pulse === 1'b1);
      if (cyc == 4000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      rst_b = 1'b0;
      {fe_clear, ne_clear, auto_eoc_mode, m4_trinal_mode, gci_master, line_signal} = 6'h00;
      line_in = '0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      foreach (rst_v[j]) exp(j, rst_v[j]);
      $display("reset values done");
      for (i = 0; i < 9; i++) begin
         d = 9'(rnd());
         ulmac_host_i.wr(i % 3, d);
         exp(i % 3, (i % 3 == 2) ? d : {1'b0, d[7:0]});
      end
      $display("host writes done");
      m4_trinal_mode <= 1'b1;
      repeat (2) pls(5'h01, 9'h0A0);
      exp(3, 9'h060);
      pls(5'h01, 9'h0A0);
      exp(3, 9'h0A0);
      exp(4, 9'h05F);
      repeat (3) pls(5'h02, 9'h0AB);
      exp(5, 9'h0AB);
      auto_eoc_mode <= 1'b1;
      repeat (3) pls(5'h02, 9'h050);
      exp(7, 9'h001);
      exp(2, 9'h050);
      repeat (3) pls(5'h02, 9'h0FF);
      exp(7, 9'h000);
      auto_eoc_mode <= 1'b0;
      $display("receive channels done");
      {line_in.linkup, line_in.superframe_sync_flag} <= 2'b11;
      // line energy lands just late enough that the request starts activation
      fork
         ulmac_host_i.activate();
         begin
            repeat (7) @(posedge ref_clk);
            line_signal <= 1'b1;
         end
      join
      for (i = 0; i < 60 && activation_status_nibble[3] !== 1'b1; i++) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      exp(6, 9'h00A);
      for (i = 0; i < 5; i++) begin
         line_in.superframe_sync_flag <= (i != 2);
         pls(5'h0C, 9'h000);
      end
      exp(10, 9'h005);
      exp(11, 9'h005);
      @(posedge ref_clk);
      {fe_clear, ne_clear, line_in.crc_err_far} <= 3'h7;
      @(posedge ref_clk);
      {fe_clear, ne_clear, line_in.crc_err_far} <= 3'h0;
      exp(10, 9'h000);
      exp(11, 9'h000);
      {line_in.linkup, line_in.superframe_sync_flag, line_signal} <= 3'b000;
      ulmac_host_i.wr(4, 9'h000);
      // warm start stands only while in teardown, so poll just after each edge
      #1;
      for (i = 0; i < 60 && warm_start_enable !== 1'b1; i++) #8;
      exp(8, 9'h001);
      ulmac_host_i.wr(3, 9'h008);
      repeat (2) @(posedge ref_clk);
      exp(9, 9'h001);
      exp(8, 9'h000);
      exp(6, 9'h000);
      ulmac_host_i.wr(3, 9'h000);
      $display("activation done");
      gci_master <= 1'b1;
      repeat (192) pls(5'h10, 9'h000);
      exp(12, 9'h002);
      gci_master <= 1'b0;
      repeat (96) pls(5'h10, 9'h000);
      exp(12, 9'h002);
      $display("frame sync done");
      print_verdict();
   end
endmodule

// ### sim/ulmac_ctl_chk.sv
// port-level assertions for the maintenance and activation control block
`timescale 1ns/1ps
module ulmac_ctl_chk (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic m4_tx_wr,
   input wire logic m56_tx_wr,
   input wire logic eoc_wr,
   input wire logic [8:0] wr_data,
   input wire logic fe_clear,
   input wire logic auto_eoc_mode,
   input wire logic gci_master,
   input wire ulmac_pkg::ulmac_line_in_t line_in,
   input wire logic [3:0] activation_status_nibble,
   input wire logic [7:0] m4_transmit_byte,
   input wire logic [7:0] m56_transmit_byte,
   input wire logic [8:0] eoc_tx,
   input wire logic [7:0] far_end_error_counter,
   input wire logic warm_start_enable,
   input wire logic soft_reset,
   input wire logic loopback_active,
   input wire logic frame_sync_pulse
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   m4_load_a: assert property (m4_tx_wr |=> m4_transmit_byte == $past(wr_data[7:0]))
      else $error("m4 transmit byte not loaded");
   m4_hold_a: assert property (!m4_tx_wr |=> $stable(m4_transmit_byte))
      else $error("m4 transmit byte changed without a write");
   m56_load_a: assert property (m56_tx_wr |=> m56_transmit_byte == $past(wr_data[7:0]))
      else $error("m56 transmit byte not loaded");
   eoc_load_a: assert property (eoc_wr && !auto_eoc_mode |=> eoc_tx == $past(wr_data))
      else $error("eoc transmit word not loaded");
   soft_clear_a: assert property (soft_reset ##1 soft_reset |->
      activation_status_nibble == 4'h0 && !warm_start_enable && !loopback_active)
      else $error("soft reset left status or warm start set");
   fe_zero_a: assert property (fe_clear |=> far_end_error_counter == 8'h00)
      else $error("far counter not cleared");
   fe_count_a: assert property (line_in.crc_err_far && !fe_clear && !soft_reset &&
      far_end_error_counter != 8'hFF |=> far_end_error_counter == $past(far_end_error_counter) + 8'h01)
      else $error("far counter missed an error");
   fs_pulse_a: assert property (frame_sync_pulse |-> $past(gci_master) ##1 !frame_sync_pulse)
      else $error("frame sync pulse wrong");
   cover property (loopback_active);
   cover property (frame_sync_pulse);
   cover property ($rose(warm_start_enable));
endmodule
bind ulmac_ctl ulmac_ctl_chk ulmac_ctl_chk_i (.ref_clk, .rst_b, .m4_tx_wr, .m56_tx_wr, .eoc_wr,
   .wr_data, .fe_clear, .auto_eoc_mode, .gci_master, .line_in, .activation_status_nibble,
   .m4_transmit_byte, .m56_transmit_byte, .eoc_tx, .far_end_error_counter,
   .warm_start_enable, .soft_reset, .loopback_active, .frame_sync_pulse);

// ### sim/ulmac_host.sv
// host controller model driving the control port strobes
`timescale 1ns/1ps
module ulmac_host (
   input wire logic ref_clk,
   output ulmac_pkg::ulmac_nib_wr_t reset_ctl_wr,
   output ulmac_pkg::ulmac_nib_wr_t act_ctl_wr,
   output logic m4_tx_wr,
   output logic m56_tx_wr,
   output logic eoc_wr,
   output logic [8:0] wr_data
);
   initial {reset_ctl_wr, act_ctl_wr, m4_tx_wr, m56_tx_wr, eoc_wr, wr_data} = '0;
   // k: 0 m4, 1 m56, 2 eoc, 3 reset nibble, 4 activation nibble
   task automatic wr(input int k, input logic [8:0] d);
      @(posedge ref_clk);
      wr_data <= d;
      {m4_tx_wr, m56_tx_wr, eoc_wr} <= {k == 0, k == 1, k == 2};
      reset_ctl_wr <= '{d[3:0], k == 3};
      act_ctl_wr <= '{d[3:0], k == 4};
      @(posedge ref_clk);
      {m4_tx_wr, m56_tx_wr, eoc_wr, reset_ctl_wr.write, act_ctl_wr.write} <= 5'h00;
      // released data bus shows a changed pattern, not the last value
      wr_data <= ~d;
   endtask
   task automatic activate();
      wr(3, 9'h008);
      wr(3, 9'h000);
      wr(0, 9'h077);
      wr(1, 9'h0FF);
      wr(4, 9'h008);
   endtask
endmodule
